// ---- shared/uefc_defs.svh ----
// Constants of the enhanced flow control block
`ifndef UEFC_DEFS_SVH
`define UEFC_DEFS_SVH
`define UEFC_A_IER 8'h00
`define UEFC_A_FCR 8'h04
`define UEFC_A_ISR 8'h08
`define UEFC_A_LCR 8'h0C
`define UEFC_A_MCR 8'h10
`define UEFC_A_LSR 8'h14
`define UEFC_A_MSR 8'h18
`define UEFC_A_SCR 8'h1C
`define UEFC_A_DLL 8'h20
`define UEFC_A_DLM 8'h24
`define UEFC_A_EFR 8'h28
`define UEFC_A_RS1 8'h2C
`define UEFC_A_RS2 8'h30
`define UEFC_A_PS1 8'h34
`define UEFC_A_PS2 8'h38
`define UEFC_A_EVT 8'h3C
`define UEFC_A_MSK 8'h40
`define UEFC_IER_ENH 8'hF0
`define UEFC_FCR_ENH 8'h30
`define UEFC_MCR_ENH 8'hE0
`define UEFC_ISR_ENH 2'h3
`define UEFC_RST_ZERO 8'h00
`define UEFC_RST_LSR 8'h60
`define UEFC_RST_SCR 8'hFF
`define UEFC_SEL_NONE 2'h0
`define UEFC_SEL_SECOND 2'h1
`define UEFC_SEL_BOTH 2'h3
`define UEFC_LCR_BREAK 6
`define UEFC_MCR_DTR 0
`define UEFC_MCR_RTS 1
`define UEFC_MCR_OUT2 3
`define UEFC_EVT_W 3
`endif

// ---- shared/uefc_pkg.sv ----
// Types of the enhanced flow control block
`default_nettype none
package uefc_pkg;
	// Enhanced feature control layout, msb first
	typedef struct packed {
		logic auto_cts;
		logic auto_rts;
		logic spec_det;
		logic enh_en;
		logic [1:0] tx_sel;
		logic [1:0] rx_sel;
	} uefc_efr_t;
	// Sticky event bits
	typedef struct packed {
		logic resume;
		logic pause;
		logic special;
	} uefc_evt_t;
	// Transmit sequencer states
	typedef enum logic [1:0] {
		UEFC_TX_IDLE,
		UEFC_TX_SECOND
	} uefc_tx_st_t;
endpackage
`default_nettype wire

// ---- rtl/uefc_top.sv ----
// Enhanced flow control and register file of one serial channel
//
// Implementation choices: the APB interface to the registers and the register addresses.
`default_nettype none
`include "uefc_defs.svh"
module uefc_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic send_pause,
	input wire logic send_resume,
	input wire logic [3:0] modem_in,
	output logic rx_store_valid,
	output logic [7:0] rx_store_data,
	output logic tx_ctrl_valid,
	output logic [7:0] tx_ctrl_data,
	output logic tx_halted,
	output logic serial_out_ch_a,
	output logic user_output2_ch_a_n,
	output logic rts_ch_a_n,
	output logic dtr_ch_a_n,
	output logic irq_out_ch_a,
	output logic irq_oe_ch_a_n
);
	// Register storage
	logic [7:0] irq_enable_reg;
	logic [7:0] fifo_ctrl_reg;
	logic [7:0] line_ctrl_reg;
	logic [7:0] modem_ctrl_reg;
	logic [7:0] line_status_reg;
	logic [7:0] scratch_reg;
	logic [7:0] divisor_low_reg;
	logic [7:0] divisor_high_byte;
	logic [1:0] isr_enh_reg;
	uefc_pkg::uefc_efr_t enhanced_feature_control;
	logic [7:0] resume_char_first;
	logic [7:0] resume_char_second;
	logic [7:0] pause_char_first;
	logic [7:0] pause_char_second;
	uefc_pkg::uefc_evt_t evt_status_reg;
	uefc_pkg::uefc_evt_t evt_mask_reg;
	// Saved enhanced fields while the gate is closed
	logic [3:0] save_ier_reg;
	logic [1:0] save_fcr_reg;
	logic [2:0] save_mcr_reg;
	logic [1:0] save_isr_reg;
	// Modem input tracking
	logic [3:0] modem_prev_reg;
	logic modem_seen_reg;
	logic [3:0] modem_delta_reg;
	// Receive sequence halves for dual mode
	logic pause_half_reg;
	logic resume_half_reg;
	// Transmit sequencer
	uefc_pkg::uefc_tx_st_t tx_st_reg;
	logic [7:0] tx_second_reg;
	// Bus decode
	logic wr_acc;
	logic rd_acc;
	logic setup;
	logic [7:0] wd;
	logic enh_fall;
	logic enh_rise;
	logic [7:0] rd_mux;
	logic rd_ok;
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign wd = pwdata[7:0];
	// Gate edges seen on a write to the feature register
	assign enh_fall = wr_acc && paddr == `UEFC_A_EFR && enhanced_feature_control.enh_en && !wd[4];
	assign enh_rise = wr_acc && paddr == `UEFC_A_EFR && !enhanced_feature_control.enh_en && wd[4];

	// Read multiplexer; unmapped offsets answer with an error
	always_comb begin
		rd_ok = 1'b1;
		rd_mux = `UEFC_RST_ZERO;
		unique case (paddr)
			`UEFC_A_IER: rd_mux = irq_enable_reg;
			`UEFC_A_FCR: rd_mux = fifo_ctrl_reg;
			// Bit 0 high means nothing pending
			`UEFC_A_ISR: rd_mux = {2'b00, isr_enh_reg, 3'b000, ~irq_out_ch_a};
			`UEFC_A_LCR: rd_mux = line_ctrl_reg;
			`UEFC_A_MCR: rd_mux = modem_ctrl_reg;
			`UEFC_A_LSR: rd_mux = line_status_reg;
			`UEFC_A_MSR: rd_mux = {modem_in, modem_delta_reg};
			`UEFC_A_SCR: rd_mux = scratch_reg;
			`UEFC_A_DLL: rd_mux = divisor_low_reg;
			`UEFC_A_DLM: rd_mux = divisor_high_byte;
			`UEFC_A_EFR: rd_mux = enhanced_feature_control;
			`UEFC_A_RS1: rd_mux = resume_char_first;
			`UEFC_A_RS2: rd_mux = resume_char_second;
			`UEFC_A_PS1: rd_mux = pause_char_first;
			`UEFC_A_PS2: rd_mux = pause_char_second;
			`UEFC_A_EVT: rd_mux = {5'b00000, evt_status_reg};
			`UEFC_A_MSK: rd_mux = {5'b00000, evt_mask_reg};
			default: rd_ok = 1'b0;
		endcase
	end

	// Answer prepared in the setup cycle so it stands in the access cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~rd_ok;
			prdata <= (setup && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
		end
	end

	// Feature and flow character registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			enhanced_feature_control <= `UEFC_RST_ZERO;
			resume_char_first <= `UEFC_RST_ZERO;
			resume_char_second <= `UEFC_RST_ZERO;
			pause_char_first <= `UEFC_RST_ZERO;
			pause_char_second <= `UEFC_RST_ZERO;
		end else if (wr_acc) begin
			if (paddr == `UEFC_A_EFR)
				enhanced_feature_control <= wd;
			if (paddr == `UEFC_A_RS1)
				resume_char_first <= wd;
			if (paddr == `UEFC_A_RS2)
				resume_char_second <= wd;
			if (paddr == `UEFC_A_PS1)
				pause_char_first <= wd;
			if (paddr == `UEFC_A_PS2)
				pause_char_second <= wd;
		end
	end

	// save enhanced fields before they are cleared
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			save_ier_reg <= 4'h0;
			save_fcr_reg <= 2'h0;
			save_mcr_reg <= 3'h0;
			save_isr_reg <= 2'h0;
		end else if (enh_fall) begin
			save_ier_reg <= irq_enable_reg[7:4];
			save_fcr_reg <= fifo_ctrl_reg[5:4];
			save_mcr_reg <= modem_ctrl_reg[7:5];
			save_isr_reg <= isr_enh_reg;
		end
	end

	// Gated control registers; legacy bits always writable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_reg <= `UEFC_RST_ZERO;
			fifo_ctrl_reg <= `UEFC_RST_ZERO;
			modem_ctrl_reg <= `UEFC_RST_ZERO;
			line_ctrl_reg <= `UEFC_RST_ZERO;
		end else if (enh_fall) begin
			irq_enable_reg <= irq_enable_reg & ~`UEFC_IER_ENH;
			fifo_ctrl_reg <= fifo_ctrl_reg & ~`UEFC_FCR_ENH;
			modem_ctrl_reg <= modem_ctrl_reg & ~`UEFC_MCR_ENH;
		end else if (enh_rise) begin
			irq_enable_reg[7:4] <= save_ier_reg;
			fifo_ctrl_reg[5:4] <= save_fcr_reg;
			modem_ctrl_reg[7:5] <= save_mcr_reg;
		end else if (wr_acc) begin
			// enhanced bits only with gate open
			if (paddr == `UEFC_A_IER)
				irq_enable_reg <= enhanced_feature_control.enh_en ? wd :
					((irq_enable_reg & `UEFC_IER_ENH) | (wd & ~`UEFC_IER_ENH));
			if (paddr == `UEFC_A_FCR)
				fifo_ctrl_reg <= enhanced_feature_control.enh_en ? wd :
					((fifo_ctrl_reg & `UEFC_FCR_ENH) | (wd & ~`UEFC_FCR_ENH));
			if (paddr == `UEFC_A_MCR)
				modem_ctrl_reg <= enhanced_feature_control.enh_en ? wd :
					((modem_ctrl_reg & `UEFC_MCR_ENH) | (wd & ~`UEFC_MCR_ENH));
			if (paddr == `UEFC_A_LCR)
				line_ctrl_reg <= wd;
		end
	end

	// Special character detection against the second pause character
	logic spec_hit;
	// bit 0 meets the received LSB
	assign spec_hit = rx_valid && enhanced_feature_control.spec_det &&
		rx_data == pause_char_second;

	// Enhanced status field; a detection outranks a clearing write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			isr_enh_reg <= 2'h0;
		end else if (enh_fall) begin
			// status field zeroed; a detection in this cycle still sets
			isr_enh_reg <= {1'b0, spec_hit};
		end else if (enh_rise) begin
			// status field back, plus any detection of this cycle
			isr_enh_reg <= save_isr_reg | {1'b0, spec_hit};
		end else begin
			if (wr_acc && paddr == `UEFC_A_ISR && enhanced_feature_control.enh_en)
				isr_enh_reg <= wd[5:4] & `UEFC_ISR_ENH;
			if (spec_hit)
				isr_enh_reg[0] <= 1'b1;
		end
	end

	// Receive comparison selection
	logic [1:0] rsel;
	logic rx_on;
	logic dual;
	logic p_m1;
	logic r_m1;
	logic p_m2;
	logic r_m2;
	logic pause_evt;
	logic resume_evt;
	logic consumed;
	assign rsel = enhanced_feature_control.rx_sel;
	// pair choice from the low bits
	assign rx_on = rsel != `UEFC_SEL_NONE;
	assign dual = rsel == `UEFC_SEL_BOTH;
	assign p_m1 = rx_data == (rsel == `UEFC_SEL_SECOND ? pause_char_second : pause_char_first);
	assign r_m1 = rx_data == (rsel == `UEFC_SEL_SECOND ? resume_char_second : resume_char_first);
	assign p_m2 = rx_data == pause_char_second;
	assign r_m2 = rx_data == resume_char_second;
	assign pause_evt = rx_valid && rx_on && (dual ? (pause_half_reg && p_m2) : p_m1);
	assign resume_evt = rx_valid && rx_on && (dual ? (resume_half_reg && r_m2) : r_m1);
	// flow characters never reach the data path while a receive selection is set
	assign consumed = rx_on && (p_m1 || r_m1 || (pause_half_reg && p_m2) ||
		(resume_half_reg && r_m2));

	// Dual sequence progress; a mismatch drops the held first half
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pause_half_reg <= 1'b0;
			resume_half_reg <= 1'b0;
		end else if (rx_valid) begin
			pause_half_reg <= dual && !pause_half_reg && p_m1;
			resume_half_reg <= dual && !resume_half_reg && r_m1;
		end
	end

	// Receive data hand-off and transmit stop state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_store_valid <= 1'b0;
			rx_store_data <= `UEFC_RST_ZERO;
			tx_halted <= 1'b0;
		end else begin
			rx_store_valid <= rx_valid && !consumed;
			if (rx_valid)
				rx_store_data <= rx_data;
			if (pause_evt)
				tx_halted <= 1'b1;
			else if (resume_evt || !rx_on)
				tx_halted <= 1'b0;
		end
	end

	// Transmit flow characters; requests while busy are dropped
	logic [1:0] tsel;
	logic [7:0] tx_c1;
	logic [7:0] tx_c2;
	assign tsel = enhanced_feature_control.tx_sel;
	assign tx_c1 = send_pause ? pause_char_first : resume_char_first;
	assign tx_c2 = send_pause ? pause_char_second : resume_char_second;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_reg <= uefc_pkg::UEFC_TX_IDLE;
			tx_ctrl_valid <= 1'b0;
			tx_ctrl_data <= `UEFC_RST_ZERO;
			tx_second_reg <= `UEFC_RST_ZERO;
		end else begin
			unique case (tx_st_reg)
				uefc_pkg::UEFC_TX_IDLE: begin
					tx_ctrl_valid <= (send_pause || send_resume) && tsel != `UEFC_SEL_NONE;
					tx_ctrl_data <= tsel == `UEFC_SEL_SECOND ? tx_c2 : tx_c1;
					tx_second_reg <= tx_c2;
					// both pairs sent as a sequence
					if ((send_pause || send_resume) && tsel == `UEFC_SEL_BOTH)
						tx_st_reg <= uefc_pkg::UEFC_TX_SECOND;
				end
				uefc_pkg::UEFC_TX_SECOND: begin
					tx_ctrl_valid <= 1'b1;
					tx_ctrl_data <= tx_second_reg;
					tx_st_reg <= uefc_pkg::UEFC_TX_IDLE;
				end
			endcase
		end
	end

	// Line status, scratch; reads of line status clear data ready
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			line_status_reg <= `UEFC_RST_LSR;
			scratch_reg <= `UEFC_RST_SCR;
		end else begin
			if (rd_acc && paddr == `UEFC_A_LSR)
				line_status_reg[0] <= 1'b0;
			if (rx_store_valid)
				line_status_reg[0] <= 1'b1;
			if (wr_acc && paddr == `UEFC_A_SCR)
				scratch_reg <= wd;
		end
	end

	// divisor bytes have no reset value
	always_ff @(posedge mclk) begin
		if (wr_acc && paddr == `UEFC_A_DLL)
			divisor_low_reg <= wd;
		if (wr_acc && paddr == `UEFC_A_DLM)
			divisor_high_byte <= wd;
	end

	// Modem change flags; a change outranks the clearing read
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			modem_prev_reg <= 4'h0;
			modem_seen_reg <= 1'b0;
			modem_delta_reg <= 4'h0;
		end else begin
			modem_prev_reg <= modem_in;
			modem_seen_reg <= 1'b1;
			// First sample after reset only seeds the history
			modem_delta_reg <= ((rd_acc && paddr == `UEFC_A_MSR) ? 4'h0 : modem_delta_reg) |
				(modem_seen_reg ? (modem_in ^ modem_prev_reg) : 4'h0);
		end
	end

	// Sticky events, write one to clear, set wins
	uefc_pkg::uefc_evt_t evt_set;
	assign evt_set = {resume_evt, pause_evt, spec_hit};
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			evt_status_reg <= 3'h0;
			evt_mask_reg <= 3'h0;
		end else begin
			evt_status_reg <= (evt_status_reg &
				~((wr_acc && paddr == `UEFC_A_EVT) ? wd[`UEFC_EVT_W-1:0] : 3'h0)) | evt_set;
			if (wr_acc && paddr == `UEFC_A_MSK)
				evt_mask_reg <= wd[`UEFC_EVT_W-1:0];
		end
	end

	// Pins; the interrupt pin floats until the first edge after reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_ch_a <= 1'b1;
			user_output2_ch_a_n <= 1'b1;
			rts_ch_a_n <= 1'b1;
			dtr_ch_a_n <= 1'b1;
			irq_out_ch_a <= 1'b0;
			irq_oe_ch_a_n <= 1'b1;
		end else begin
			serial_out_ch_a <= ~line_ctrl_reg[`UEFC_LCR_BREAK];
			user_output2_ch_a_n <= ~modem_ctrl_reg[`UEFC_MCR_OUT2];
			rts_ch_a_n <= ~modem_ctrl_reg[`UEFC_MCR_RTS];
			dtr_ch_a_n <= ~modem_ctrl_reg[`UEFC_MCR_DTR];
			irq_out_ch_a <= |(evt_status_reg & evt_mask_reg);
			irq_oe_ch_a_n <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- bench/uefc_top_sva.sv ----
// Port checker of the enhanced flow control block
`default_nettype none
`include "uefc_defs.svh"
module uefc_top_sva (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic send_pause,
	input wire logic rx_store_valid,
	input wire logic [7:0] rx_store_data,
	input wire logic tx_ctrl_valid,
	input wire logic [7:0] tx_ctrl_data,
	input wire logic tx_halted,
	input wire logic serial_out_ch_a,
	input wire logic user_output2_ch_a_n,
	input wire logic rts_ch_a_n,
	input wire logic dtr_ch_a_n,
	input wire logic irq_out_ch_a,
	input wire logic irq_oe_ch_a_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] efr_reg; // Copy of the feature byte
	logic [7:0] p1_reg; // Copy of the first pause character
	logic [7:0] p2_reg; // Copy of the second pause character
	logic [7:0] msk_reg; // Copy of the event mask
	// Copies follow only writes that the block accepted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			efr_reg <= 8'h00;
			p1_reg <= 8'h00;
			p2_reg <= 8'h00;
			msk_reg <= 8'h00;
		end else if (psel && penable && pwrite && pready) begin
			case (paddr)
				`UEFC_A_EFR: efr_reg <= pwdata[7:0];
				`UEFC_A_PS1: p1_reg <= pwdata[7:0];
				`UEFC_A_PS2: p2_reg <= pwdata[7:0];
				`UEFC_A_MSK: msk_reg <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	property p_rst_pins;
		disable iff (1'b0) !rst_n ##1 !rst_n |-> serial_out_ch_a && user_output2_ch_a_n
			&& rts_ch_a_n && dtr_ch_a_n && irq_oe_ch_a_n;
	endproperty
	a_rst_pins: assert property (p_rst_pins)
		else $error("pins not idle in reset");
	property p_oe;
		$rose(rst_n) |=> !irq_oe_ch_a_n;
	endproperty
	a_oe: assert property (p_oe)
		else $error("interrupt pin not driven after reset");
	property p_rx_none;
		rx_valid && efr_reg[1:0] == 2'h0 |=> rx_store_valid && rx_store_data == $past(rx_data);
	endproperty
	a_rx_none: assert property (p_rx_none)
		else $error("character not stored");
	property p_det;
		rx_valid && efr_reg[5] && efr_reg[1:0] == 2'h0 && rx_data == p2_reg && msk_reg[0]
			|-> ##[1:3] irq_out_ch_a;
	endproperty
	a_det: assert property (p_det)
		else $error("special character not flagged");
	property p_tx_single;
		send_pause && efr_reg[3] != efr_reg[2]
			|=> tx_ctrl_valid && tx_ctrl_data == (efr_reg[3] ? p1_reg : p2_reg);
	endproperty
	a_tx_single: assert property (p_tx_single)
		else $error("wrong single pause character");
	property p_tx_dual;
		tx_ctrl_valid && efr_reg[3:2] == 2'h3 && tx_ctrl_data == p1_reg
			|=> tx_ctrl_valid && tx_ctrl_data == p2_reg;
	endproperty
	a_tx_dual: assert property (p_tx_dual)
		else $error("dual pause not sent in sequence");
	property p_rx_single;
		rx_valid && efr_reg[1] != efr_reg[0] && rx_data == (efr_reg[1] ? p1_reg : p2_reg)
			|=> !rx_store_valid && tx_halted;
	endproperty
	a_rx_single: assert property (p_rx_single)
		else $error("single pause not taken");
	property p_rx_dual;
		rx_valid && efr_reg[1:0] == 2'h3 && rx_data == p1_reg ##1 rx_valid && rx_data == p2_reg
			|=> !rx_store_valid && tx_halted;
	endproperty
	a_rx_dual: assert property (p_rx_dual)
		else $error("dual pause not taken");
endmodule
bind uefc_top uefc_top_sva u_uefc_top_sva (.*);
`default_nettype wire

// ---- bench/uefc_remote.sv ----
// Remote serial device model on the line side
`default_nettype none
module uefc_remote (
	input wire logic mclk,
	input wire logic tx_ctrl_valid,
	input wire logic [7:0] tx_ctrl_data,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$]; // Flow characters heard from the block
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h5A;
	end
	always @(posedge mclk) begin
		if (tx_ctrl_valid === 1'b1) begin
			got.push_back(tx_ctrl_data);
		end
	end
	// Gap zero sends back to back; idle data is inverted so it never looks valid
	task automatic send(input logic [7:0] c[$], input int gap);
		foreach (c[i]) begin
			rx_valid <= 1'b1;
			rx_data <= c[i];
			@(posedge mclk);
			if (gap > 0) begin
				rx_valid <= 1'b0;
				rx_data <= ~c[i];
				repeat (gap) @(posedge mclk);
			end
		end
		if (gap == 0) begin
			rx_valid <= 1'b0;
			rx_data <= ~c[c.size() - 1];
			@(posedge mclk);
		end
	endtask
endmodule
`default_nettype wire

// ---- bench/uefc_top_tb.sv ----
// Self-checking bench of the enhanced flow control block
`default_nettype none
`include "uefc_defs.svh"
module uefc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic send_pause = 1'b0;
	logic send_resume = 1'b0;
	logic [3:0] modem_in = 4'hA; // Seen live in modem status
	logic [31:0] prdata;
	logic pready, pslverr, rx_store_valid, tx_ctrl_valid, tx_halted, rx_valid;
	logic [7:0] rx_store_data, tx_ctrl_data, rx_data;
	logic serial_out_ch_a, user_output2_ch_a_n, rts_ch_a_n, dtr_ch_a_n;
	logic irq_out_ch_a, irq_oe_ch_a_n;
	int num_errors = 0;
	int cmp_count = 0;
	logic [7:0] rst_a [0:9] = '{`UEFC_A_IER, `UEFC_A_FCR, `UEFC_A_ISR, `UEFC_A_LCR,
		`UEFC_A_MCR, `UEFC_A_LSR, `UEFC_A_MSR, `UEFC_A_SCR, `UEFC_A_EFR, `UEFC_A_MSK};
	logic [7:0] rst_v [0:9] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hA0, 8'hFF,
		8'h00, 8'h00};
	logic [7:0] gate_a [0:2] = '{`UEFC_A_IER, `UEFC_A_FCR, `UEFC_A_MCR};
	logic [7:0] gate_m [0:2] = '{`UEFC_IER_ENH, `UEFC_FCR_ENH, `UEFC_MCR_ENH};
	always #25 mclk = ~mclk;
	uefc_top u_uefc_top (.*);
	uefc_remote u_uefc_remote (.*);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// One APB transfer, then an idle edge so strobes are never reassigned at once
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		bus(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		logic [31:0] q;
		logic e;
		bus(1'b0, a, 8'h00, q, e);
		chk($sformatf("reg_%h", a), {24'h00_0000, x}, q);
	endtask
	task automatic test_done;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		logic [31:0] q;
		logic e;
		logic [7:0] exp_q[$];
		repeat (12) @(posedge mclk);
		chk("rst_pins", 32'h0000_001F, {27'h0, serial_out_ch_a, user_output2_ch_a_n,
			rts_ch_a_n, dtr_ch_a_n, irq_oe_ch_a_n});
		rst_n <= 1'b1;
		@(posedge mclk);
		foreach (rst_a[i]) rd(rst_a[i], rst_v[i]);
		bus(1'b0, 8'h44, 8'h00, q, e);
		chk("unmapped_err", 32'h0000_0001, {31'h0, e});
		chk("unmapped_data", 32'h0000_0000, q);
		// Enhanced fields: refused, kept, saved and zeroed, restored
		foreach (gate_a[i]) begin
			wr(gate_a[i], gate_m[i]);
			rd(gate_a[i], 8'h00);
			wr(`UEFC_A_EFR, 8'h10);
			wr(gate_a[i], gate_m[i]);
			rd(gate_a[i], gate_m[i]);
			wr(`UEFC_A_EFR, 8'h00);
			rd(gate_a[i], 8'h00);
			wr(`UEFC_A_EFR, 8'h10);
			rd(gate_a[i], gate_m[i]);
			wr(`UEFC_A_EFR, 8'h00);
		end
		wr(`UEFC_A_EFR, 8'h10);
		foreach (gate_a[i]) wr(gate_a[i], 8'h00);
		wr(`UEFC_A_MCR, 8'h0B);
		wr(`UEFC_A_LCR, 8'h40);
		@(posedge mclk);
		chk("pins", 32'h0, {28'h0, serial_out_ch_a, user_output2_ch_a_n, rts_ch_a_n,
			dtr_ch_a_n});
		wr(`UEFC_A_MCR, 8'h00);
		wr(`UEFC_A_LCR, 8'h00);
		wr(`UEFC_A_RS1, 8'h11);
		wr(`UEFC_A_RS2, 8'h13);
		wr(`UEFC_A_PS1, 8'h21);
		wr(`UEFC_A_PS2, 8'h23);
		wr(`UEFC_A_MSK, 8'h01);
		wr(`UEFC_A_EFR, 8'h30);
		u_uefc_remote.send('{8'hC4}, 0);
		rd(`UEFC_A_EVT, 8'h00);
		rd(`UEFC_A_LSR, 8'h61);
		rd(`UEFC_A_LSR, 8'h60);
		u_uefc_remote.send('{8'h23}, 0);
		rd(`UEFC_A_EVT, 8'h01);
		rd(`UEFC_A_ISR, 8'h10);
		rd(`UEFC_A_LSR, 8'h61);
		chk("irq_set", 32'h1, {31'h0, irq_out_ch_a});
		wr(`UEFC_A_EVT, 8'h01);
		@(posedge mclk);
		chk("irq_clr", 32'h0, {31'h0, irq_out_ch_a});
		// Status field: written open, saved and zeroed, refused closed, restored
		wr(`UEFC_A_ISR, 8'h20);
		rd(`UEFC_A_ISR, 8'h21);
		wr(`UEFC_A_EFR, 8'h20);
		rd(`UEFC_A_ISR, 8'h01);
		wr(`UEFC_A_ISR, 8'h30);
		rd(`UEFC_A_ISR, 8'h01);
		wr(`UEFC_A_EFR, 8'h30);
		rd(`UEFC_A_ISR, 8'h21);
		// Single pairs, answered slowly
		for (int s = 1; s < 3; s++) begin
			wr(`UEFC_A_EFR, {6'h04, s[1:0]});
			u_uefc_remote.send('{s[1] ? 8'h21 : 8'h23}, 2);
			chk("halt_set", 32'h1, {31'h0, tx_halted});
			u_uefc_remote.send('{s[1] ? 8'h11 : 8'h13}, 2);
			chk("halt_clr", 32'h0, {31'h0, tx_halted});
		end
		rd(`UEFC_A_EVT, 8'h06);
		wr(`UEFC_A_EVT, 8'h06);
		wr(`UEFC_A_EFR, 8'h13);
		u_uefc_remote.send('{8'h21, 8'h23}, 0);
		chk("dual_halt", 32'h1, {31'h0, tx_halted});
		u_uefc_remote.send('{8'h11, 8'h13}, 1);
		chk("dual_resume", 32'h0, {31'h0, tx_halted});
		u_uefc_remote.send('{8'h21, 8'h55, 8'h23}, 0);
		chk("dual_broken", 32'h0, {31'h0, tx_halted});
		// Every transmit selection, pause then resume
		for (int s = 0; s < 4; s++) begin
			wr(`UEFC_A_EFR, {4'h1, s[1:0], 2'h0});
			send_pause <= 1'b1;
			@(posedge mclk);
			send_pause <= 1'b0;
			repeat (3) @(posedge mclk);
			send_resume <= 1'b1;
			@(posedge mclk);
			send_resume <= 1'b0;
			repeat (3) @(posedge mclk);
			if (s[1]) exp_q.push_back(8'h21);
			if (s[0]) exp_q.push_back(8'h23);
			if (s[1]) exp_q.push_back(8'h11);
			if (s[0]) exp_q.push_back(8'h13);
		end
		chk("tx_count", exp_q.size(), u_uefc_remote.got.size());
		foreach (exp_q[i]) begin
			chk("tx_char", {24'h00_0000, exp_q[i]}, {24'h00_0000, u_uefc_remote.got[i]});
		end
		// Modem inputs shown live; a change flags every moved bit until read
		modem_in <= 4'h5;
		repeat (2) @(posedge mclk);
		rd(`UEFC_A_MSR, 8'h5F);
		rd(`UEFC_A_MSR, 8'h50);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		test_done();
	end
endmodule
`default_nettype wire
